// ==== sim/duart_host_model.sv ====
// host processor model: one strobed access per call
`default_nettype none
module duart_host_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] rdata_i,
    output var  logic       sel_one_n_o,
    output var  logic       sel_two_n_o,
    output var  logic [2:0] addr_o,
    output var  logic       rd_o,
    output var  logic       wr_o,
    output var  logic [7:0] wdata_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {sel_one_n_o, sel_two_n_o, rd_o, wr_o} = 4'hC;
        addr_o = 3'h0;
        wdata_o = 8'h00;
    end
    // ch 1 takes register set 1 (channel two pin), 0 set 0 (channel one pin), 2 both pins
    task automatic access(input logic [1:0] ch, input logic [2:0] a, input logic w,
                          input logic [7:0] d, output logic [7:0] q);
        @(posedge clk_i);
        #10;
        sel_one_n_o = !(ch == 2'd0 || ch == 2'd2);
        sel_two_n_o = !(ch == 2'd1 || ch == 2'd2);
        addr_o = a;
        wdata_o = d;
        rd_o = !w;
        wr_o = w;
        @(posedge clk_i);
        #10;
        q = rdata_i;
        {sel_one_n_o, sel_two_n_o, rd_o, wr_o} = 4'hC;
        // stale data would hide a missing write
        wdata_o = ~d;
    endtask
endmodule
`default_nettype wire

// ==== sim/duart_regs_assertions.sv ====
// register file port checks
`default_nettype none
module duart_regs_assertions #(
    parameter int CHANNELS = 2
) (
    input wire logic                                   clk_i,
    input wire logic                                   reset_n_i,
    input wire logic                                   channel_one_select_n_i,
    input wire logic                                   channel_two_select_n_i,
    input wire logic [2:0]                             addr_i,
    input wire logic                                   rd_i,
    input wire logic                                   wr_i,
    input wire logic [7:0]                             wdata_i,
    input var  duart_pkg::duart_status_type [CHANNELS-1:0] status_i,
    input wire logic [7:0]                             rdata_o,
    input var  duart_pkg::duart_event_type  [CHANNELS-1:0] event_o,
    input var  duart_pkg::duart_config_type [CHANNELS-1:0] config_o
);
    logic       s_one;
    logic       s_two;
    logic [7:0] fmt1;
    logic       gate1;
    // s_one takes register set index 1, which the channel two pin selects
    assign s_one = channel_one_select_n_i && !channel_two_select_n_i;
    assign s_two = !channel_one_select_n_i && channel_two_select_n_i;
    assign fmt1  = config_o[1].character_format;
    assign gate1 = config_o[1].enhanced_features[4];
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    ////////////////////////////////////////////////////////////////////////////
    unsel_read_a: assert property (rd_i && channel_one_select_n_i == channel_two_select_n_i
        |=> $stable(rdata_o)) else $error("unselected read moved read data");
    fmt_write_a: assert property (wr_i && s_two && addr_i == 3'h3
        |=> config_o[0].character_format == $past(wdata_i)) else $error("format not stored");
    scratch_store_a: assert property (wr_i && s_one && addr_i == 3'h7 && fmt1 != 8'hBF
        |=> config_o[1].scratch_byte == $past(wdata_i)) else $error("scratch not stored");
    status_wr_a: assert property (wr_i && s_one && addr_i inside {3'h5, 3'h6} && fmt1 != 8'hBF
        |=> $stable(config_o[1])) else $error("reserved write changed state");
    tx_load_a: assert property (wr_i && s_one && addr_i == 3'h0 && !fmt1[7]
        |=> event_o[1].tx_load && event_o[1].tx_holding == $past(wdata_i))
        else $error("transmit byte not loaded");
    divisor_low_a: assert property (wr_i && s_one && addr_i == 3'h0 && fmt1[7] && fmt1 != 8'hBF
        |=> config_o[1].baud_divisor[7:0] == $past(wdata_i)) else $error("divisor low wrong");
    ien_gate_a: assert property (wr_i && s_one && addr_i == 3'h1 && !fmt1[7] && !gate1
        |=> config_o[1].interrupt_enables == ($past(config_o[1].interrupt_enables) & 8'hF0
        | $past(wdata_i) & 8'h0F)) else $error("gated enables written");
    isrc_read_a: assert property (rd_i && s_one && addr_i == 3'h2 && fmt1 != 8'hBF && !gate1
        |=> rdata_o[5:4] == 2'h0 && rdata_o[0] == !$past(status_i[1].int_pending))
        else $error("interrupt status wrong");
    efr_read_a: assert property (rd_i && s_one && addr_i == 3'h2 && fmt1 == 8'hBF
        |=> rdata_o == $past(config_o[1].enhanced_features)) else $error("enhanced read wrong");
    ien_read_a: assert property (rd_i && s_one && addr_i == 3'h1 && !fmt1[7] && !gate1
        |=> rdata_o[7:4] == 4'h0) else $error("hidden enables visible");
    rx_read_a: assert property (rd_i && s_one && addr_i == 3'h0 && !fmt1[7]
        |=> event_o[1].rx_read) else $error("receive read not reported");
    cover property (wr_i && s_one && addr_i == 3'h0 && fmt1[7]);
    cover property (rd_i && s_one && addr_i == 3'h2 && fmt1 == 8'hBF);
    cover property (event_o[1].tx_load);
endmodule
bind duart_regs duart_regs_assertions #(.CHANNELS(CHANNELS)) u_regs_chk (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .channel_one_select_n_i(channel_one_select_n_i),
    .channel_two_select_n_i(channel_two_select_n_i), .addr_i(addr_i), .rd_i(rd_i),
    .wr_i(wr_i), .wdata_i(wdata_i), .status_i(status_i), .rdata_o(rdata_o),
    .event_o(event_o), .config_o(config_o));
`default_nettype wire

// ==== sim/test_duart_regs.sv ====
// testbench for the dual serial register file
`default_nettype none
module test_duart_regs;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, reset_n, s1n, s2n, rd, wr;
    logic [2:0] addr;
    logic [7:0] wdata, rdata;
    duart_pkg::duart_status_type [1:0] st;
    duart_pkg::duart_event_type  [1:0] ev;
    duart_pkg::duart_config_type [1:0] cfg;
    int num_errors = 0;
    int checks = 0;
    int cycles = 0;
    duart_host_model u_host (.clk_i(clk), .rdata_i(rdata), .sel_one_n_o(s1n),
        .sel_two_n_o(s2n), .addr_o(addr), .rd_o(rd), .wr_o(wr), .wdata_o(wdata));
    duart_regs #(.CHANNELS(2)) dut (.clk_i(clk), .reset_n_i(reset_n),
        .channel_one_select_n_i(s1n), .channel_two_select_n_i(s2n), .addr_i(addr),
        .rd_i(rd), .wr_i(wr), .wdata_i(wdata), .status_i(st), .rdata_o(rdata),
        .event_o(ev), .config_o(cfg));
    ////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr_reg(input logic [1:0] ch, input logic [2:0] a, input logic [7:0] d);
        logic [7:0] q;
        u_host.access(ch, a, 1'b1, d, q);
    endtask
    task automatic rd_reg(input logic [1:0] ch, input logic [2:0] a, input logic [7:0] e,
                          input string n);
        logic [7:0] q;
        u_host.access(ch, a, 1'b0, 8'h00, q);
        chk(n, e, q);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            wrap_up();
        end
    end
    initial begin
        reset_n = 1'b0;
        st[1] = '{8'h3C, 8'h61, 8'hB0, 6'h3C, 1'b1};
        st[0] = '0;
        repeat (12) @(posedge clk);
        #10 reset_n = 1'b1;
        rd_reg(2'd1, 3'h3, 8'h00, "format reset");
        wr_reg(2'd1, 3'h3, 8'h03);
        wr_reg(2'd0, 3'h3, 8'h1B);
        rd_reg(2'd1, 3'h3, 8'h03, "format one");
        rd_reg(2'd0, 3'h3, 8'h1B, "format two");
        wr_reg(2'd1, 3'h0, 8'hA5);
        chk("tx byte", 8'hA5, ev[1].tx_holding);
        chk("tx pulse", 8'h01, {7'h00, ev[1].tx_load});
        rd_reg(2'd1, 3'h0, 8'h3C, "rx byte");
        wr_reg(2'd1, 3'h1, 8'hFF);
        rd_reg(2'd1, 3'h1, 8'h0F, "enables gated");
        wr_reg(2'd1, 3'h4, 8'hFF);
        rd_reg(2'd1, 3'h4, 8'h1F, "outputs gated");
        wr_reg(2'd1, 3'h7, 8'h5A);
        wr_reg(2'd2, 3'h7, 8'hC3);
        rd_reg(2'd2, 3'h7, 8'h1F, "unselected read");
        rd_reg(2'd1, 3'h7, 8'h5A, "scratch");
        rd_reg(2'd0, 3'h7, 8'h00, "scratch two");
        wr_reg(2'd1, 3'h5, 8'hFF);
        wr_reg(2'd1, 3'h6, 8'hFF);
        rd_reg(2'd1, 3'h5, 8'h61, "line state");
        rd_reg(2'd1, 3'h6, 8'hB0, "modem state");
        wr_reg(2'd1, 3'h2, 8'hF7);
        chk("queue resets", 8'h03, {6'h00, ev[1].tx_queue_reset, ev[1].rx_queue_reset});
        chk("queue control", 8'hC1, cfg[1].queue_control);
        rd_reg(2'd1, 3'h2, 8'hCC, "int pending");
        st[1].int_pending = 1'b0;
        rd_reg(2'd1, 3'h2, 8'hCD, "int idle");
        wr_reg(2'd1, 3'h3, 8'h80);
        wr_reg(2'd1, 3'h0, 8'h34);
        wr_reg(2'd1, 3'h1, 8'h12);
        chk("divisor high", 8'h12, cfg[1].baud_divisor[15:8]);
        rd_reg(2'd1, 3'h0, 8'h34, "divisor low");
        wr_reg(2'd1, 3'h3, 8'hBF);
        wr_reg(2'd1, 3'h2, 8'h10);
        for (int i = 0; i < 4; i++) wr_reg(2'd1, 3'(4 + i), 8'(8'h11 + i));
        rd_reg(2'd1, 3'h2, 8'h10, "enhanced");
        for (int i = 0; i < 4; i++) rd_reg(2'd1, 3'(4 + i), 8'(8'h11 + i), "flow char");
        wr_reg(2'd1, 3'h3, 8'h03);
        rd_reg(2'd1, 3'h7, 8'h5A, "scratch kept");
        wr_reg(2'd1, 3'h1, 8'hFF);
        rd_reg(2'd1, 3'h1, 8'hFF, "enables open");
        wr_reg(2'd1, 3'h4, 8'hFF);
        rd_reg(2'd1, 3'h4, 8'hFF, "outputs open");
        st[1].int_pending = 1'b1;
        rd_reg(2'd1, 3'h2, 8'hFC, "status open");
        wr_reg(2'd1, 3'h3, 8'hBF);
        wr_reg(2'd1, 3'h2, 8'h00);
        wr_reg(2'd1, 3'h3, 8'h03);
        rd_reg(2'd1, 3'h1, 8'h0F, "enables hidden");
        rd_reg(2'd1, 3'h4, 8'h1F, "outputs hidden");
        wr_reg(2'd1, 3'h1, 8'h00);
        chk("enables kept", 8'hF0, cfg[1].interrupt_enables);
        wrap_up();
    end
endmodule
`default_nettype wire

// ==== src/duart_pkg.sv ====
// types shared by the dual serial register file
`default_nettype none
package duart_pkg;
    typedef struct packed {
        logic [7:0] rx_holding;
        logic [7:0] link_condition;
        logic [7:0] handshake_inputs;
        logic [5:0] int_code;
        logic       int_pending;
    } duart_status_type;

    typedef struct packed {
        logic [7:0] tx_holding;
        logic       tx_load;
        logic       rx_read;
        logic       link_read;
        logic       hsi_read;
        logic       isrc_read;
        logic       rx_queue_reset;
        logic       tx_queue_reset;
    } duart_event_type;

    typedef struct packed {
        logic [15:0] baud_divisor;
        logic [7:0]  interrupt_enables;
        logic [7:0]  queue_control;
        logic [7:0]  character_format;
        logic [7:0]  handshake_outputs;
        logic [7:0]  enhanced_features;
        logic [7:0]  flow_resume_char_1;
        logic [7:0]  flow_resume_char_2;
        logic [7:0]  flow_pause_char_1;
        logic [7:0]  flow_pause_char_2;
        logic [7:0]  scratch_byte;
    } duart_config_type;
endpackage
`default_nettype wire

// ==== src/duart_regs.sv ====
// two-channel register file and address decoder for the dual serial controller
`include "duart_regs_defines.svh"
`default_nettype none
module duart_regs #(
    parameter int CHANNELS = 2
) (
    input  wire logic                                 clk_i,
    input  wire logic                                 reset_n_i,
    input  wire logic                                 channel_one_select_n_i,
    input  wire logic                                 channel_two_select_n_i,
    input  wire logic [2:0]                           addr_i,
    input  wire logic                                 rd_i,
    input  wire logic                                 wr_i,
    input  wire logic [7:0]                           wdata_i,
    input  var  duart_pkg::duart_status_type [CHANNELS-1:0] status_i,
    output logic [7:0]                                rdata_o,
    output var  duart_pkg::duart_event_type  [CHANNELS-1:0] event_o,
    output var  duart_pkg::duart_config_type [CHANNELS-1:0] config_o
);

    if (CHANNELS != 2) begin : g_bad_channels
        $error("duart_regs serves exactly two channels");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // channel select: one chip select each, both asserted reaches nothing

    logic [CHANNELS-1:0] sel;
    assign sel = {~channel_two_select_n_i & channel_one_select_n_i,
                  ~channel_one_select_n_i & channel_two_select_n_i}; // R01

    logic [7:0] rdata_d;
    logic [7:0] rdata_q;
    logic [CHANNELS-1:0][7:0] ch_rdata;

    ////////////////////////////////////////////////////////////////////////////////
    // per-channel register sets

    for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
        duart_pkg::duart_config_type cfg_d;
        duart_pkg::duart_config_type cfg_q;
        duart_pkg::duart_event_type  ev_d;
        duart_pkg::duart_event_type  ev_q;
        logic [7:0] rd_val;
        logic       enh_bank;
        logic       div_sel;
        logic       gate_on;
        logic [7:0] ien_mask;
        logic [7:0] hso_mask;
        logic [7:0] qctl_mask;
        logic       wr_en;
        logic       rd_en;

        assign wr_en    = wr_i & sel[c];
        assign rd_en    = rd_i & sel[c];
        assign enh_bank = cfg_q.character_format == `DUART_ENH_KEY; // R13 R14
        assign div_sel  = cfg_q.character_format[`DUART_FMT_DIV_BIT] & ~enh_bank; // R03
        assign gate_on  = cfg_q.enhanced_features[`DUART_EFR_GATE_BIT]; // R15
        // hidden bits keep their stored value, so reopening the gate brings them back
        assign ien_mask  = gate_on ? 8'hFF : ~`DUART_IEN_GATED; // R15 R16
        assign hso_mask  = gate_on ? 8'hFF : ~`DUART_HSO_GATED; // R15 R16
        assign qctl_mask = gate_on ? 8'hFF : ~`DUART_QCTL_GATED; // R15 R16

        always_comb begin
            cfg_d = cfg_q;
            ev_d  = '0;
            ev_d.tx_holding = ev_q.tx_holding;
            if (wr_en) begin
                if (addr_i == `DUART_OFS_FMT) begin
                    cfg_d.character_format = wdata_i; // R07
                end else if (addr_i == `DUART_OFS_HOLD) begin
                    if (cfg_q.character_format[`DUART_FMT_DIV_BIT]) begin
                        cfg_d.baud_divisor[7:0] = wdata_i; // R03
                    end else begin
                        ev_d.tx_holding = wdata_i; // R02
                        ev_d.tx_load    = 1'b1;
                    end
                end else if (addr_i == `DUART_OFS_IEN) begin
                    if (cfg_q.character_format[`DUART_FMT_DIV_BIT]) begin
                        cfg_d.baud_divisor[15:8] = wdata_i; // R03
                    end else begin
                        cfg_d.interrupt_enables = (cfg_q.interrupt_enables & ~ien_mask)
                                                | (wdata_i & ien_mask); // R04 R16
                    end
                end else if (addr_i == `DUART_OFS_ISRC) begin
                    if (enh_bank) begin
                        cfg_d.enhanced_features = wdata_i; // R13
                    end else begin
                        // reset bits self-clear: they are reported as one-cycle events
                        cfg_d.queue_control = ((cfg_q.queue_control & ~qctl_mask)
                            | (wdata_i & qctl_mask)) & ~`DUART_QCTL_RST_MASK; // R05 R06 R16
                        ev_d.rx_queue_reset = wdata_i[1]; // R06
                        ev_d.tx_queue_reset = wdata_i[2]; // R06
                    end
                end else if (addr_i == `DUART_OFS_HSO) begin
                    if (enh_bank) begin
                        cfg_d.flow_resume_char_1 = wdata_i; // R14
                    end else begin
                        cfg_d.handshake_outputs = (cfg_q.handshake_outputs & ~hso_mask)
                                                | (wdata_i & hso_mask); // R08 R16
                    end
                end else if (addr_i == `DUART_OFS_LINK) begin // R11
                    if (enh_bank) begin
                        cfg_d.flow_resume_char_2 = wdata_i; // R14
                    end
                end else if (addr_i == `DUART_OFS_HSI) begin // R11
                    if (enh_bank) begin
                        cfg_d.flow_pause_char_1 = wdata_i; // R14
                    end
                end else begin
                    if (enh_bank) begin
                        cfg_d.flow_pause_char_2 = wdata_i; // R14
                    end else begin
                        cfg_d.scratch_byte = wdata_i; // R12
                    end
                end
            end
            if (rd_en) begin
                ev_d.rx_read   = addr_i == `DUART_OFS_HOLD
                                 && !cfg_q.character_format[`DUART_FMT_DIV_BIT];
                ev_d.isrc_read = addr_i == `DUART_OFS_ISRC && !enh_bank;
                ev_d.link_read = addr_i == `DUART_OFS_LINK && !enh_bank;
                ev_d.hsi_read  = addr_i == `DUART_OFS_HSI && !enh_bank;
            end
        end

        always_comb begin
            rd_val = 8'h00;
            if (addr_i == `DUART_OFS_FMT) begin
                rd_val = cfg_q.character_format; // R07
            end else if (addr_i == `DUART_OFS_HOLD) begin
                rd_val = cfg_q.character_format[`DUART_FMT_DIV_BIT]
                       ? cfg_q.baud_divisor[7:0] : status_i[c].rx_holding; // R02 R03
            end else if (addr_i == `DUART_OFS_IEN) begin
                rd_val = cfg_q.character_format[`DUART_FMT_DIV_BIT]
                       ? cfg_q.baud_divisor[15:8] : cfg_q.interrupt_enables & ien_mask; // R03 R04 R16
            end else if (addr_i == `DUART_OFS_ISRC) begin
                if (enh_bank) begin
                    rd_val = cfg_q.enhanced_features; // R13
                end else begin
                    rd_val = {{2{cfg_q.queue_control[0]}},
                              status_i[c].int_code[5:1], ~status_i[c].int_pending}; // R05 R17
                    if (!gate_on) begin
                        rd_val = rd_val & ~`DUART_ISRC_GATED; // R15 R16
                    end
                end
            end else if (addr_i == `DUART_OFS_HSO) begin
                rd_val = enh_bank ? cfg_q.flow_resume_char_1
                                  : cfg_q.handshake_outputs & hso_mask; // R08 R16
            end else if (addr_i == `DUART_OFS_LINK) begin
                rd_val = enh_bank ? cfg_q.flow_resume_char_2
                                  : status_i[c].link_condition; // R09
            end else if (addr_i == `DUART_OFS_HSI) begin
                rd_val = enh_bank ? cfg_q.flow_pause_char_1
                                  : status_i[c].handshake_inputs; // R10
            end else begin
                rd_val = enh_bank ? cfg_q.flow_pause_char_2 : cfg_q.scratch_byte; // R12 R14
            end
        end

        always_ff @(posedge clk_i or negedge reset_n_i) begin
            if (!reset_n_i) begin
                cfg_q <= '0;
                ev_q  <= '0;
            end else begin
                cfg_q <= cfg_d;
                ev_q  <= ev_d;
            end
        end

        assign ch_rdata[c] = rd_val;
        assign config_o[c] = cfg_q;
        assign event_o[c]  = ev_q;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read data: registered, held between reads

    always_comb begin
        rdata_d = rdata_q;
        if (rd_i && sel[0]) begin
            rdata_d = ch_rdata[0];
        end else if (rd_i && sel[1]) begin
            rdata_d = ch_rdata[1];
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign rdata_o = rdata_q;

endmodule
`default_nettype wire

// ==== src/duart_regs_defines.svh ====
// register offsets, field positions and reset values for the dual serial register file
// Functional notes
// R01: Each channel has its own register set, picked by its chip select, with the register picked by three address lines.
// R02: At offset 0 with format bit 7 clear, reads return the receive byte and writes load the transmit byte.
// R03: With format bit 7 set and format not 0xBF, offsets 0 and 1 reach the low and high divisor bytes; the code also reaches them with format 0xBF.
// R04: At offset 1 with format bit 7 clear, the interrupt enables are read/write with the documented bit meanings.
// R05: At offset 2 outside the enhanced bank, reads give interrupt status with FIFO-enabled in bits 7-6 and writes go to queue control.
// R06: The write-only queue control byte holds FIFO enable, receive reset, transmit reset, DMA mode and trigger level.
// R07: The character format register at offset 3 is always reachable.
// R08: Handshake outputs at offset 4 outside the enhanced bank hold the eight documented control bits.
// R09: Link condition at offset 5 is read-only.
// R10: Handshake inputs at offset 6 are read-only, with change flags low and current states high.
// R11: Writes to offsets 5 and 6 outside the enhanced bank change nothing.
// R12: Offset 7 outside the enhanced bank is a scratch byte read back unchanged.
// R13: With format equal to 0xBF, offset 2 reaches the enhanced feature register.
// R14: With format equal to 0xBF, offsets 4 to 7 reach the two resume and two pause characters.
// R15: Enhanced bit 4 gates enable bits 7-4, status bits 5-4, queue bits 5-4 and handshake bits 7-5.
// R16: While enhanced bit 4 is clear the gated bits read zero and writes to them are ignored.
// R17: Interrupt status bit 0 reads one when nothing is pending and zero otherwise.
`ifndef DUART_REGS_DEFINES_SVH
`define DUART_REGS_DEFINES_SVH

`define DUART_OFS_HOLD      3'h0
`define DUART_OFS_IEN       3'h1
`define DUART_OFS_ISRC      3'h2
`define DUART_OFS_FMT       3'h3
`define DUART_OFS_HSO       3'h4
`define DUART_OFS_LINK      3'h5
`define DUART_OFS_HSI       3'h6
`define DUART_OFS_SCR       3'h7

`define DUART_ENH_KEY       8'hBF
`define DUART_FMT_DIV_BIT   7
`define DUART_EFR_GATE_BIT  4
`define DUART_IEN_GATED     8'hF0
`define DUART_ISRC_GATED    8'h30
`define DUART_QCTL_GATED    8'h30
`define DUART_HSO_GATED     8'hE0
`define DUART_QCTL_RST_MASK 8'h06
`define DUART_REG_RESET     8'h00
`define DUART_FMT_RESET     8'h00

`endif
